// ### common/prl_pkg.sv
// Constants shared by the parallel RGB panel output block.
// Assumes a 50 MHz system clock and a panel on a 24-bit parallel RGB link.
package prl_pkg;

	// ----------------------------------------------------------------
	// Lane layout of the pixel data bus.
	// ----------------------------------------------------------------
	localparam int PRL_BLUE_LSB  = 0;
	localparam int PRL_GREEN_LSB = 8;
	localparam int PRL_RED_LSB   = 16;
	localparam int PRL_LANE_W    = 8;
	localparam int PRL_BUS_W     = 24;

	// ----------------------------------------------------------------
	// Default timing counts, horizontal in pixel clocks and vertical in lines, and the clock divider.
	// ----------------------------------------------------------------
	localparam int PRL_H_ACTIVE = 16;
	localparam int PRL_H_FRONT  = 2;
	localparam int PRL_H_SYNC   = 2;
	localparam int PRL_H_BACK   = 2;
	localparam int PRL_V_ACTIVE = 4;
	localparam int PRL_V_FRONT  = 1;
	localparam int PRL_V_SYNC   = 1;
	localparam int PRL_V_BACK   = 1;
	localparam int PRL_CLK_DIV  = 4;

	// ----------------------------------------------------------------
	// Reset values of the outputs.
	// ----------------------------------------------------------------
	localparam logic [23:0] PRL_DATA_RST = 24'h000000;

endpackage

// ### src/prl_rgb_out.sv
// Parallel RGB panel output: pixel clock, sync pulses, enable and colour lanes.
// Assumes pixel colour comes from same-clock logic and is taken while o_pix_req is high.
// Data, enable and syncs change together at the rise of the sent pixel clock and then
// stand for one whole pixel period, so the panel may sample anywhere inside it.
// The sent pixel clock is a divided copy of i_clk; CLK_DIV must be two or more.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Blue sits on data lines 0 to 7; 18-bit panels ignore lines 0 and 1.
// - Green sits on data lines 8 to 15; 18-bit panels ignore lines 8 and 9.
// - Red sits on data lines 16 to 23; 18-bit panels ignore lines 16 and 17.
// - Display enable is high for every active pixel and low in all blanking.
// - Frame sync pulses high at each frame start, low otherwise.
// - Line sync pulses high at each line start, low otherwise.
// - Data, enable and syncs change together with the rising edge of the sent pixel clock; o_pix_req rises one clock earlier.
module prl_rgb_out
	import prl_pkg::*;
#(
	parameter int H_ACTIVE = PRL_H_ACTIVE,
	parameter int H_FRONT  = PRL_H_FRONT,
	parameter int H_SYNC   = PRL_H_SYNC,
	parameter int H_BACK   = PRL_H_BACK,
	parameter int V_ACTIVE = PRL_V_ACTIVE,
	parameter int V_FRONT  = PRL_V_FRONT,
	parameter int V_SYNC   = PRL_V_SYNC,
	parameter int V_BACK   = PRL_V_BACK,
	parameter int CLK_DIV  = PRL_CLK_DIV
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	input  wire logic [PRL_LANE_W-1:0] i_red,
	input  wire logic [PRL_LANE_W-1:0] i_green,
	input  wire logic [PRL_LANE_W-1:0] i_blue,
	output logic                       o_pix_req,
	output logic                       o_panel_pixel_clock,
	output logic                       o_panel_display_enable,
	output logic                       o_frame_sync_out,
	output logic                       o_line_sync_out,
	output logic [PRL_BUS_W-1:0]       o_pixel_data_bus
);

	// ----------------------------------------------------------------
	// Derived sizes.
	// ----------------------------------------------------------------
	localparam int H_TOTAL = H_SYNC + H_BACK + H_ACTIVE + H_FRONT;
	localparam int V_TOTAL = V_SYNC + V_BACK + V_ACTIVE + V_FRONT;
	localparam int HW = $clog2(H_TOTAL);
	localparam int VW = $clog2(V_TOTAL);
	localparam int DW = $clog2(CLK_DIV);
	localparam logic [DW-1:0] DIV_LAST = DW'(CLK_DIV - 1);
	localparam logic [DW-1:0] DIV_HALF = DW'(CLK_DIV / 2);
	localparam logic [DW-1:0] DIV_PRE  = DW'(CLK_DIV - 2);
	// The raster restarts on its last position, so the first pixel clock opens a frame.
	localparam logic [HW-1:0] H_START  = HW'(H_TOTAL - 1);
	localparam logic [VW-1:0] V_START  = VW'(V_TOTAL - 1);
	// Expected run lengths of the level outputs, in system clocks, for the checks.
	localparam logic [15:0]   LS_CLKS  = 16'(H_SYNC * CLK_DIV);
	localparam logic [15:0]   FS_CLKS  = 16'(V_SYNC * H_TOTAL * CLK_DIV);
	localparam logic [15:0]   DE_CLKS  = 16'(H_ACTIVE * CLK_DIV);

	// Tells whether a counter value lies in [lo, lo+len).
	function automatic logic in_span(input int val, input int lo, input int len);
		in_span = (val >= lo) && (val < lo + len);
	endfunction

	// Registered state: divider, raster position and every panel-side output.
	logic [DW-1:0] div_q;
	logic [HW-1:0] h_q;
	logic [VW-1:0] v_q;
	logic          pclk_q;
	logic          de_q;
	logic          fs_q;
	logic          ls_q;
	logic          req_q;
	logic [23:0]   data_q;

	// ----------------------------------------------------------------
	// Pixel clock tick and raster position decode.
	// ----------------------------------------------------------------
	// The divider wraps to zero, which is the rising edge of the sent clock.
	// The next raster position and the levels that it calls for are applied at that edge.
	wire   rise_tick = (div_q == DIV_LAST);
	wire   h_last    = (h_q == HW'(H_TOTAL - 1));
	wire   v_last    = (v_q == VW'(V_TOTAL - 1));
	wire [HW-1:0] h_nx = h_last ? '0 : h_q + HW'(1);
	wire [VW-1:0] v_nx = h_last ? (v_last ? '0 : v_q + VW'(1)) : v_q;
	wire   h_act_nx  = in_span(int'(h_nx), H_SYNC + H_BACK, H_ACTIVE);
	wire   v_act_nx  = in_span(int'(v_nx), V_SYNC + V_BACK, V_ACTIVE);
	wire   de_nx     = h_act_nx && v_act_nx;
	wire   ls_nx     = in_span(int'(h_nx), 0, H_SYNC);
	wire   fs_nx     = in_span(int'(v_nx), 0, V_SYNC);
	wire [23:0] pix_nx = de_nx ? {i_red, i_green, i_blue} : PRL_DATA_RST;

	// ----------------------------------------------------------------
	// Clock divider: sent pixel clock is high in the first half period.
	// ----------------------------------------------------------------
	// The clock only goes high on a divider wrap, so no stray rise leaves reset
	// ahead of the first pixel; it then stays high for DIV_HALF system clocks.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_q  <= '0;
			pclk_q <= 1'b0;
		end else begin
			div_q  <= rise_tick ? '0 : div_q + DW'(1);
			pclk_q <= rise_tick || (pclk_q && (div_q + DW'(1) < DIV_HALF));
		end
	end

	// Raster counters advance once per pixel clock. They leave reset on the last
	// position, so the first output edge shows a complete frame and line sync.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			h_q <= H_START;
			v_q <= V_START;
		end else if (rise_tick) begin
			h_q <= h_nx;
			v_q <= v_nx;
		end
	end

	// All panel outputs update on the same edge the sent clock rises.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			de_q   <= 1'b0;
			fs_q   <= 1'b0;
			ls_q   <= 1'b0;
			data_q <= PRL_DATA_RST;
		end else if (rise_tick) begin
			de_q   <= de_nx;
			fs_q   <= fs_nx;
			ls_q   <= ls_nx;
			data_q <= pix_nx;
		end
	end

	// Colour request pulse, one clock, in the cycle the pixel is taken. It is raised
	// one clock ahead so that the output comes from a flip-flop; the raster counters
	// do not move between that clock and the taking edge, so de_nx already holds.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			req_q <= 1'b0;
		end else begin
			req_q <= (div_q == DIV_PRE) && de_nx;
		end
	end

	// Outputs come straight from their flip-flops.
	assign o_pix_req              = req_q;
	assign o_panel_pixel_clock    = pclk_q;
	assign o_panel_display_enable = de_q;
	assign o_frame_sync_out       = fs_q;
	assign o_line_sync_out        = ls_q;
	assign o_pixel_data_bus       = data_q;

	// ----------------------------------------------------------------
	// Check helpers: run lengths of the level outputs.
	// ----------------------------------------------------------------
	logic [15:0] ls_run_q;
	logic [15:0] fs_run_q;
	logic [15:0] de_run_q;

	// Each counter counts system clocks while its output stands high and clears when it is low,
	// so at a falling edge it holds the whole width of the pulse just ended.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ls_run_q <= '0;
			fs_run_q <= '0;
			de_run_q <= '0;
		end else begin
			ls_run_q <= o_line_sync_out ? ls_run_q + 16'h0001 : '0;
			fs_run_q <= o_frame_sync_out ? fs_run_q + 16'h0001 : '0;
			de_run_q <= o_panel_display_enable ? de_run_q + 16'h0001 : '0;
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	// They watch the panel-side outputs on the system clock, as the panel would see them.
	a_blue_lane: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rise_tick && de_nx |=> o_pixel_data_bus[7:0] == $past(i_blue))
		else $error("blue lane wrong");
	a_green_lane: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rise_tick && de_nx |=> o_pixel_data_bus[15:8] == $past(i_green))
		else $error("green lane wrong");
	a_red_lane: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rise_tick && de_nx |=> o_pixel_data_bus[23:16] == $past(i_red))
		else $error("red lane wrong");
	a_de_blank: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_panel_display_enable |-> !o_line_sync_out && !o_frame_sync_out)
		else $error("enable high in blanking");
	a_frame_start: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rise_tick && h_last && v_last |=> o_frame_sync_out)
		else $error("frame sync missing");
	a_line_start: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		rise_tick && h_last |=> o_line_sync_out)
		else $error("line sync missing");
	a_edge_align: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$changed(o_line_sync_out) |-> $rose(o_panel_pixel_clock))
		else $error("outputs moved off clock edge");
	a_line_width: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$fell(o_line_sync_out) |-> ls_run_q == LS_CLKS)
		else $error("line sync width wrong");
	a_frame_width: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$fell(o_frame_sync_out) |-> fs_run_q == FS_CLKS)
		else $error("frame sync width wrong");
	a_active_width: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$fell(o_panel_display_enable) |-> de_run_q == DE_CLKS)
		else $error("display enable width wrong");
	a_req_lead: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_pix_req |=> $rose(o_panel_pixel_clock) && o_panel_display_enable)
		else $error("taken pixel not shown at clock rise");
	a_req_spacing: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_pix_req |=> !o_pix_req)
		else $error("colour requests back to back");

	// Main scenarios: frame start, line start, active run, a taken pixel, line sync in frame sync.
	c_frame: cover property (@(posedge i_clk) $rose(o_frame_sync_out));
	c_line: cover property (@(posedge i_clk) $rose(o_line_sync_out));
	c_active: cover property (@(posedge i_clk) $rose(o_panel_display_enable));
	c_request: cover property (@(posedge i_clk) o_pix_req);
	c_sync_pair: cover property (@(posedge i_clk) $rose(o_line_sync_out) && o_frame_sync_out);

endmodule

`default_nettype wire

// ### dv/prl_panel_model.sv
// Panel model: takes one pixel at each rise of the sent pixel clock.
// Assumes every link output is a register of the i_clk domain.
`timescale 1ns/1ns
`default_nettype none
module prl_panel_model (
	input  wire logic        i_clk,
	input  wire logic        i_pclk,
	input  wire logic        i_de,
	input  wire logic        i_vs,
	input  wire logic        i_hs,
	input  wire logic [23:0] i_data,
	output logic             o_stb,
	output logic [23:0]      o_data,
	output logic [17:0]      o_data18,
	output logic [2:0]       o_ctl
);
	logic pclk_q = 1'b0;
	// Sample on the clock rise only, as a real panel would.
	always @(posedge i_clk) begin
		o_stb <= i_pclk && !pclk_q;
		pclk_q <= i_pclk;
		if (i_pclk && !pclk_q) begin
			o_data <= i_data;
			o_data18 <= {i_data[23:18], i_data[15:10], i_data[7:2]};
			o_ctl <= {i_de, i_vs, i_hs};
		end
	end
endmodule
`default_nettype wire

// ### dv/tb_parallel_rgb_lcd_output.sv
// Bench: random colours in, panel-side pixels checked against a queue.
// Assumes the panel model above and short timing counts.
`timescale 1ns/1ns
`default_nettype none
module tb_parallel_rgb_lcd_output;
	import prl_pkg::*;
	localparam int HA = 5, HS = 2, VA = 3, VS = 1, HT = 11;
	logic i_clk = 1'b0, i_arst_n = 1'b0, req, pclk, de, vs, hs, stb;
	logic [7:0] r = 8'h00, g = 8'h00, b = 8'h00;
	logic [23:0] bus, d, dl, e;
	logic [17:0] d18;
	logic [2:0] c, pc = 3'h0;
	logic pl = 1'b0;
	logic [23:0] q[$];
	int fail_count = 0, comparisons = 0, cyc = 0, frames = 0, lines = 0, der = 0, hsr = 0, vsr = 0;
	prl_rgb_out #(.H_ACTIVE(HA), .H_SYNC(HS), .V_ACTIVE(VA), .V_SYNC(VS)) uut (.i_clk(i_clk),
		.i_arst_n(i_arst_n), .i_red(r), .i_green(g), .i_blue(b), .o_pix_req(req),
		.o_panel_pixel_clock(pclk), .o_panel_display_enable(de), .o_frame_sync_out(vs),
		.o_line_sync_out(hs), .o_pixel_data_bus(bus));
	prl_panel_model pnl (.i_clk(i_clk), .i_pclk(pclk), .i_de(de), .i_vs(vs), .i_hs(hs),
		.i_data(bus), .o_stb(stb), .o_data(d), .o_data18(d18), .o_ctl(c));
	always #10 i_clk = ~i_clk;
	task automatic chk(input string n, input logic [23:0] x, input logic [23:0] y);
		comparisons++;
		if (x !== y) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Fresh random colour every cycle; only those taken on a request are noted.
	always @(posedge i_clk) begin
		#1 {r, g, b} <= 24'($urandom);
		if (++cyc > 2000) begin
			fail_count++;
			close_out();
		end
	end
	// Notes and checks run on the falling edge, where everything has settled.
	always @(negedge i_clk) begin
		if (i_arst_n && req === 1'b1) q.push_back({r, g, b});
		if (i_arst_n && !(pclk === 1'b1 && !pl)) chk("hold", dl, bus);
		pl = pclk;
		dl = bus;
		if (stb === 1'b1) begin
			if (c[2]) begin
				e = q.size() ? q.pop_front() : 'x;
				chk("pixel", e, d);
				chk("pixel18", {6'h00, e[23:18], e[15:10], e[7:2]}, {6'h00, d18});
			end else chk("blank", 24'h000000, d);
			if (pc[2] && !c[2]) chk("de_run", 24'(HA), 24'(der));
			if (pc[2] && !c[2]) lines++;
			if (pc[0] && !c[0]) chk("hs_run", 24'(HS), 24'(hsr));
			if (pc[1] && !c[1]) chk("vs_run", 24'(VS * HT), 24'(vsr));
			if (!pc[1] && c[1]) begin
				chk("hs_at_vs", 24'h000001, {23'h0, c[0]});
				if (frames > 0) chk("lines", 24'(VA), 24'(lines));
				if (frames > 0) $display("frame %0d done", frames);
				frames++;
				lines = 0;
			end
			der = c[2] ? der + 1 : 0;
			hsr = c[0] ? hsr + 1 : 0;
			vsr = c[1] ? vsr + 1 : 0;
			pc = c;
		end
	end
	initial begin
		void'($urandom(62330));
		repeat (5) @(posedge i_clk);
		#1 i_arst_n = 1'b1;
		wait (frames == 4);
		close_out();
	end
endmodule
`default_nettype wire
